/* rtl/rcr_regs.sv */
`timescale 1ns/100ps

// Operation
// - Acts only as a two-wire bus slave, fast mode up to 400 kbps.
// - Write address C2, C4 or C6 chosen by the two select pins.
// - Read address C3, C5 or C7: write address with direction bit set.
// - Every byte on the link is shifted most significant bit first.
// - Write: pointer byte, then data to successive registers, each byte acknowledged.
// - Read returns the zero reserved byte, then status; master ends with NACK.
// - Register 00: clock output divider bit 7, whole divider part bits 6-0, reset 56.
// - Clock output divider bit: 0 passes reference, 1 halves it.
// - Register 01 resets 1e; bit 4 fractional mode; bits 3-0 fraction top.
// - Registers 02 and 03 hold fraction bits 15-0, reset 90 and 69.
// - Register 04 resets 60; bit 7 selects reference division by two.
// - Pump current select bit: 0 low current, 1 high current.
// - Second LO divider bit: 0 divides by four, 1 by eight.
// - Shutdown bits of register 04: 0 keeps section on, 1 shuts it down.
// - Register 05 resets 04; five-bit gain loop threshold field.
// - Lowpass corner nudge: 10 nominal, 11 lower, 00 higher.
// - Backend gain boost, register 05 bit 0, adds gain when set.
// - Register 06 four-bit front gain cutback field, value in dB.
// - Clock buffer off bit: 0 keeps reference buffer running, 1 stops it.
// - Test select: 000 normal, 001 main divider out, 010 reference divider out.
// - Register 09 trim source: 0 factory trim, 1 serially written trim code.
// - Feed overcurrent flag set while the feed current limit engages.
// - Feed load present flag set while feed current exceeds sense threshold.
module rcr_regs (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Two-wire serial port, data is open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Address select pins
  input wire logic addr_select_hi,
  input wire logic addr_select_lo,
  // Status from the analog sections
  input wire logic feed_overcurrent_in,
  input wire logic feed_load_in,
  input wire logic gain_loop_engaged_in,
  input wire logic pll_lock_in,
  // Reference clock and factory trim
  input wire logic ref_clk_in,
  input wire logic [4:0] factory_trim_code,
  // Synthesizer controls
  output logic clock_out_divider,
  output logic [6:0] divider_whole_part,
  output logic [19:0] divider_fraction_part,
  output logic fractional_mode,
  output logic reserved_synth_bit,
  output logic [1:0] reserved_pump_bits,
  output logic ref_divide_two,
  output logic pump_current_select,
  output logic second_lo_divider,
  // Section shutdowns
  output logic gain_loop_off,
  output logic feed_guard_off,
  output logic front_stage_off,
  output logic rear_stage_off,
  output logic synth_off,
  output logic clock_buffer_off,
  // Gain and filter trims
  output logic [4:0] gain_loop_threshold,
  output logic [1:0] lowpass_corner_nudge,
  output logic backend_gain_boost,
  output logic [3:0] front_gain_cutback,
  output logic lowpass_trim_source,
  output logic [4:0] lowpass_trim_code,
  output logic [4:0] lowpass_trim_applied,
  // Test and clock outputs
  output logic [2:0] test_select,
  output logic test_route_main,
  output logic test_route_ref,
  output logic buffered_clock_out
);

  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  logic [13:0] sync_w;
  logic scl_s;
  logic sda_s;
  logic sel_hi_s;
  logic sel_lo_s;
  logic ovc_s;
  logic load_s;
  logic agc_s;
  logic lock_s;
  logic ref_s;
  logic [4:0] factory_s;

  rcr_sync #(
    .WIDTH(14),
    .RESET_VALUE(14'h3000)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .async_in({scl_in, sda_in, addr_select_hi, addr_select_lo, feed_overcurrent_in, feed_load_in,
               gain_loop_engaged_in, pll_lock_in, ref_clk_in, factory_trim_code}),
    .sync_out(sync_w)
  );

  assign scl_s = sync_w[13];
  assign sda_s = sync_w[12];
  assign sel_hi_s = sync_w[11];
  assign sel_lo_s = sync_w[10];
  assign ovc_s = sync_w[9];
  assign load_s = sync_w[8];
  assign agc_s = sync_w[7];
  assign lock_s = sync_w[6];
  assign ref_s = sync_w[5];
  assign factory_s = sync_w[4:0];

  // ----------------------------------------
  // Bus condition detection
  // ----------------------------------------
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_rise_w;
  logic scl_fall_w;
  logic start_w;
  logic stop_w;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  assign scl_rise_w = scl_s & ~scl_prev_q;
  assign scl_fall_w = ~scl_s & scl_prev_q;
  assign start_w = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_w = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // ----------------------------------------
  // Address match and read data
  // ----------------------------------------
  // Both select pins low gives no address, so the device stays silent then.
  logic addr_valid_w;
  logic [6:0] dev_addr_w;
  logic addr_hit_w;
  logic [7:0] status_byte_w;
  logic [7:0] rd_byte_w;
  rcr_pkg::rcr_state_t state_q;
  rcr_pkg::rcr_state_t state_d;
  logic [3:0] bit_cnt_q;
  logic [3:0] bit_cnt_d;
  logic ack_q;
  logic ack_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [7:0] tx_q;
  logic [7:0] tx_d;
  logic [7:0] ptr_q;
  logic [7:0] ptr_d;
  logic [1:0] rd_idx_q;
  logic [1:0] rd_idx_d;
  logic rnw_q;
  logic rnw_d;
  logic nack_q;
  logic nack_d;
  logic sda_low_q;
  logic sda_low_d;
  logic wr_en_w;
  logic byte_end_w;
  logic [7:0] reg_q [0:9];

  assign addr_valid_w = sel_hi_s | sel_lo_s;
  assign dev_addr_w = {rcr_pkg::DEV_ADDR_UPPER, sel_hi_s, sel_lo_s};
  assign addr_hit_w = addr_valid_w & (shift_q[7:1] == dev_addr_w);
  assign status_byte_w = {4'h0, agc_s, ovc_s, load_s, lock_s};
  assign rd_byte_w = (rd_idx_q == 2'h1) ? status_byte_w : rcr_pkg::RESERVED_BYTE;
  assign byte_end_w = scl_fall_w & ~ack_q & (bit_cnt_q == rcr_pkg::BITS_PER_BYTE);

  // ----------------------------------------
  // Serial slave sequencer
  // ----------------------------------------
  // Bits are sampled on the synchronised clock rising edge; at 100 MHz a fast-mode
  // high phase of 600 ns gives ample margin for the two-stage delay.
  always_comb
  begin
    state_d = state_q;
    bit_cnt_d = bit_cnt_q;
    ack_d = ack_q;
    shift_d = shift_q;
    tx_d = tx_q;
    ptr_d = ptr_q;
    rd_idx_d = rd_idx_q;
    rnw_d = rnw_q;
    nack_d = nack_q;
    sda_low_d = sda_low_q;
    wr_en_w = 1'b0;
    if (stop_w)
    begin
      state_d = rcr_pkg::ST_IDLE;
      sda_low_d = 1'b0;
      ack_d = 1'b0;
    end
    else if (start_w)
    begin
      state_d = rcr_pkg::ST_DEV;
      bit_cnt_d = 4'h0;
      ack_d = 1'b0;
      sda_low_d = 1'b0;
    end
    else
    begin
      case (state_q)
        rcr_pkg::ST_DEV, rcr_pkg::ST_PTR, rcr_pkg::ST_WDATA:
        begin
          if (scl_rise_w && !ack_q && bit_cnt_q != rcr_pkg::BITS_PER_BYTE)
          begin
            shift_d = {shift_q[6:0], sda_s};
            bit_cnt_d = bit_cnt_q + 4'h1;
          end
          else if (byte_end_w)
          begin
            ack_d = 1'b1;
            sda_low_d = 1'b1;
            if (state_q == rcr_pkg::ST_DEV)
            begin
              rnw_d = shift_q[0];
              if (!addr_hit_w)
              begin
                state_d = rcr_pkg::ST_IDLE;
                ack_d = 1'b0;
                sda_low_d = 1'b0;
              end
            end
            else if (state_q == rcr_pkg::ST_PTR)
            begin
              ptr_d = shift_q;
            end
            else
            begin
              wr_en_w = 1'b1;
              ptr_d = ptr_q + 8'h01;
            end
          end
          else if (scl_fall_w && ack_q)
          begin
            ack_d = 1'b0;
            bit_cnt_d = 4'h0;
            sda_low_d = 1'b0;
            if (state_q == rcr_pkg::ST_DEV && rnw_q)
            begin
              state_d = rcr_pkg::ST_RDATA;
              tx_d = rcr_pkg::RESERVED_BYTE;
              sda_low_d = ~rcr_pkg::RESERVED_BYTE[7];
              rd_idx_d = 2'h1;
            end
            else if (state_q == rcr_pkg::ST_DEV)
            begin
              state_d = rcr_pkg::ST_PTR;
            end
            else
            begin
              state_d = rcr_pkg::ST_WDATA;
            end
          end
        end
        rcr_pkg::ST_RDATA:
        begin
          if (scl_rise_w && ack_q)
          begin
            nack_d = sda_s;
          end
          else if (scl_rise_w)
          begin
            bit_cnt_d = bit_cnt_q + 4'h1;
          end
          else if (byte_end_w)
          begin
            ack_d = 1'b1;
            sda_low_d = 1'b0;
          end
          else if (scl_fall_w && !ack_q)
          begin
            tx_d = {tx_q[6:0], 1'b0};
            sda_low_d = ~tx_q[6];
          end
          else if (scl_fall_w)
          begin
            ack_d = 1'b0;
            bit_cnt_d = 4'h0;
            if (nack_q)
            begin
              state_d = rcr_pkg::ST_HOLD;
              sda_low_d = 1'b0;
            end
            else
            begin
              tx_d = rd_byte_w;
              sda_low_d = ~rd_byte_w[7];
              if (rd_idx_q != 2'h2)
              begin
                rd_idx_d = rd_idx_q + 2'h1;
              end
            end
          end
        end
        default:
        begin
          state_d = state_q;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= rcr_pkg::ST_IDLE;
      bit_cnt_q <= 4'h0;
      ack_q <= 1'b0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      rd_idx_q <= 2'h0;
      rnw_q <= 1'b0;
      nack_q <= 1'b0;
      sda_low_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      bit_cnt_q <= bit_cnt_d;
      ack_q <= ack_d;
      shift_q <= shift_d;
      tx_q <= tx_d;
      ptr_q <= ptr_d;
      rd_idx_q <= rd_idx_d;
      rnw_q <= rnw_d;
      nack_q <= nack_d;
      sda_low_q <= sda_low_d;
    end
  end

  // The pin is open drain: the level driven is always low, only the enable moves.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end
    else
    begin
      sda_out <= 1'b0;
      sda_oe <= sda_low_d;
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  // Offsets outside storage, and spare slots with a zero write mask, take the
  // write and its acknowledge but change nothing.
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < rcr_pkg::REG_SLOTS; i++)
      begin
        reg_q[i] <= rcr_pkg::REG_RESET[i];
      end
    end
    else
    begin
      for (int i = 0; i < rcr_pkg::REG_SLOTS; i++)
      begin
        if (wr_en_w && ptr_q == 8'(i))
        begin
          reg_q[i] <= (reg_q[i] & ~rcr_pkg::REG_WMASK[i]) | (shift_q & rcr_pkg::REG_WMASK[i]);
        end
      end
    end
  end

  // ----------------------------------------
  // Field outputs
  // ----------------------------------------
  assign clock_out_divider = reg_q[0][rcr_pkg::CLK_OUT_DIV_BIT];
  assign divider_whole_part = reg_q[0][6:0];
  assign divider_fraction_part = {reg_q[1][3:0], reg_q[2], reg_q[3]};
  assign fractional_mode = reg_q[1][rcr_pkg::FRAC_MODE_BIT];
  assign reserved_synth_bit = reg_q[1][7];
  assign reserved_pump_bits = reg_q[1][6:5];
  assign ref_divide_two = reg_q[4][rcr_pkg::REF_DIV_BIT];
  assign pump_current_select = reg_q[4][rcr_pkg::PUMP_SEL_BIT];
  assign second_lo_divider = reg_q[4][rcr_pkg::LO_DIV_BIT];
  assign gain_loop_off = reg_q[4][rcr_pkg::GAIN_LOOP_OFF_BIT];
  assign feed_guard_off = reg_q[4][rcr_pkg::FEED_GUARD_OFF_BIT];
  assign front_stage_off = reg_q[4][rcr_pkg::FRONT_OFF_BIT];
  assign rear_stage_off = reg_q[4][rcr_pkg::REAR_OFF_BIT];
  assign synth_off = reg_q[4][rcr_pkg::SYNTH_OFF_BIT];
  assign gain_loop_threshold = reg_q[5][rcr_pkg::THRESH_LSB +: 5];
  assign lowpass_corner_nudge = reg_q[5][rcr_pkg::NUDGE_LSB +: 2];
  assign backend_gain_boost = reg_q[5][rcr_pkg::BOOST_BIT];
  assign front_gain_cutback = reg_q[6][rcr_pkg::CUTBACK_LSB +: 4];
  assign clock_buffer_off = reg_q[6][rcr_pkg::CLK_BUF_OFF_BIT];
  assign test_select = reg_q[6][rcr_pkg::TEST_LSB +: 3];
  assign lowpass_trim_source = reg_q[9][rcr_pkg::TRIM_SRC_BIT];
  assign lowpass_trim_code = reg_q[9][4:0];

  // ----------------------------------------
  // Derived controls and reference clock output
  // ----------------------------------------
  // The reference is resampled at 100 MHz, so its output edges carry up to one
  // system period of jitter; it suits slow references only.
  logic ref_prev_q;
  logic ref_half_q;
  logic ref_rise_w;
  logic clk_out_w;
  logic [4:0] trim_w;

  assign ref_rise_w = ref_s & ~ref_prev_q;
  assign clk_out_w = clock_buffer_off ? 1'b0 : (clock_out_divider ? ref_half_q : ref_s);
  assign trim_w = lowpass_trim_source ? lowpass_trim_code : factory_s;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ref_prev_q <= 1'b0;
      ref_half_q <= 1'b0;
      buffered_clock_out <= 1'b0;
      lowpass_trim_applied <= 5'h00;
      test_route_main <= 1'b0;
      test_route_ref <= 1'b0;
    end
    else
    begin
      ref_prev_q <= ref_s;
      ref_half_q <= ref_half_q ^ ref_rise_w;
      buffered_clock_out <= clk_out_w;
      lowpass_trim_applied <= trim_w;
      test_route_main <= (test_select == rcr_pkg::TEST_MAIN_DIV);
      test_route_ref <= (test_select == rcr_pkg::TEST_REF_DIV);
    end
  end

endmodule

/* include/rcr_pkg.sv */
package rcr_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] SYNTH_INTEGER_OFS = 8'h00;
  localparam logic [7:0] SYNTH_FRACTION_HIGH_OFS = 8'h01;
  localparam logic [7:0] SYNTH_FRACTION_MID_OFS = 8'h02;
  localparam logic [7:0] SYNTH_FRACTION_LOW_OFS = 8'h03;
  localparam logic [7:0] CONTROL_OFS = 8'h04;
  localparam logic [7:0] GAIN_FILTER_TRIM_OFS = 8'h05;
  localparam logic [7:0] FRONT_GAIN_AND_TEST_OFS = 8'h06;
  localparam logic [7:0] SPARE_ONE_OFS = 8'h07;
  localparam logic [7:0] SPARE_TWO_OFS = 8'h08;
  localparam logic [7:0] LOWPASS_TRIM_OFS = 8'h09;
  localparam logic [7:0] SPARE_ZERO_OFS = 8'h10;
  localparam int REG_SLOTS = 10;

  // ----------------------------------------
  // Reset values and writable bits, indexed by offset
  // ----------------------------------------
  localparam logic [7:0] REG_RESET [0:9] = '{8'h56, 8'h1e, 8'h90, 8'h69, 8'h60, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] REG_WMASK [0:9] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h3f};

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CLK_OUT_DIV_BIT = 7;
  localparam int FRAC_MODE_BIT = 4;
  localparam int REF_DIV_BIT = 7;
  localparam int PUMP_SEL_BIT = 6;
  localparam int LO_DIV_BIT = 5;
  localparam int GAIN_LOOP_OFF_BIT = 4;
  localparam int FEED_GUARD_OFF_BIT = 3;
  localparam int FRONT_OFF_BIT = 2;
  localparam int REAR_OFF_BIT = 1;
  localparam int SYNTH_OFF_BIT = 0;
  localparam int THRESH_LSB = 3;
  localparam int NUDGE_LSB = 1;
  localparam int BOOST_BIT = 0;
  localparam int CUTBACK_LSB = 4;
  localparam int CLK_BUF_OFF_BIT = 3;
  localparam int TEST_LSB = 0;
  localparam int TRIM_SRC_BIT = 5;

  // ----------------------------------------
  // Serial link and test select constants
  // ----------------------------------------
  localparam logic [4:0] DEV_ADDR_UPPER = 5'h18;
  localparam logic [7:0] RESERVED_BYTE = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] TEST_NORMAL = 3'h0;
  localparam logic [2:0] TEST_MAIN_DIV = 3'h1;
  localparam logic [2:0] TEST_REF_DIV = 3'h2;

  typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_PTR, ST_WDATA, ST_RDATA, ST_HOLD} rcr_state_t;

endpackage

/* rtl/rcr_sync.sv */
`timescale 1ns/100ps

// ----------------------------------------
// Two-stage synchroniser for asynchronous levels
// ----------------------------------------
// Idle-high pins reset to their idle level, so no false edge follows reset.
module rcr_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_q <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

/* testbench/rcr_regs_chk.sv */
`timescale 1ns/100ps

// ----------------
// Port checker
// ----------------
module rcr_regs_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Serial port and select pins
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic addr_select_hi,
  input wire logic addr_select_lo,
  // Derived outputs
  input wire logic lowpass_trim_source,
  input wire logic [4:0] lowpass_trim_code,
  input wire logic [4:0] lowpass_trim_applied,
  input wire logic [2:0] test_select,
  input wire logic test_route_main,
  input wire logic test_route_ref,
  input wire logic clock_buffer_off,
  input wire logic buffered_clock_out
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  a_pin_open_drain: assert property (sda_out == 1'b0)
    else $error("data pin output value not low");
  // Enable changes are timed from the synchronised clock fall, so they land well inside the low phase.
  a_oe_after_fall: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in, 3))
    else $error("data enable moved outside the clock low phase");
  a_oe_steady_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("data enable moved while clock high");
  a_unselected_silent: assert property ((!addr_select_hi && !addr_select_lo) [*8] |-> !sda_oe)
    else $error("device answered with both select pins low");
  a_trim_follows_code: assert property (lowpass_trim_source && $past(lowpass_trim_source)
    |-> lowpass_trim_applied == $past(lowpass_trim_code))
    else $error("written trim code not applied");
  a_test_route_decode: assert property (test_route_main == ($past(test_select) == rcr_pkg::TEST_MAIN_DIV)
    && test_route_ref == ($past(test_select) == rcr_pkg::TEST_REF_DIV))
    else $error("test route does not match test select");
  a_buffer_off_quiet: assert property (clock_buffer_off && $past(clock_buffer_off) |-> !buffered_clock_out)
    else $error("clock output active while buffer off");
  a_outputs_after_reset: assert property ($rose(rst_b) |-> lowpass_trim_applied == 5'h00 && !test_route_main
    && !test_route_ref && !buffered_clock_out && !sda_oe)
    else $error("outputs not at reset state after release");
endmodule

/* testbench/rcr_master.sv */
`timescale 1ns/100ps

// ----------------
// Bus master model
// ----------------
module rcr_master (
  // Clock
  input wire logic sys_clk,
  // Bus pins, data is pulled up when released
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Quarter bit of 500 ns keeps clock phases at 1 us, above the slave's sampling latency.
  task automatic tick();
    repeat (50) @(negedge sys_clk);
  endtask

  task automatic bit_io(input logic b, output logic r);
    sda_pull = !b;
    tick();
    scl = 1'b1;
    tick();
    r = sda;
    tick();
    scl = 1'b0;
    tick();
  endtask

  task automatic start();
    sda_pull = 1'b1;
    tick();
    scl = 1'b0;
    tick();
  endtask

  task automatic stop();
    sda_pull = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    sda_pull = 1'b0;
    tick();
    tick();
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask

  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, b[i]);
    bit_io(last, r);
  endtask

  task automatic write_frame(input logic [7:0] bytes [$], output logic [15:0] acks);
    logic a;
    acks = 16'h0000;
    start();
    foreach (bytes[i])
    begin
      send_byte(bytes[i], a);
      acks[i] = a;
    end
    stop();
  endtask

  task automatic read_frame(input logic [7:0] addr, output logic ack, output logic [7:0] b0, output logic [7:0] b1);
    start();
    send_byte(addr, ack);
    b0 = 8'h00;
    b1 = 8'h00;
    if (ack)
    begin
      recv_byte(1'b0, b0);
      recv_byte(1'b1, b1);
    end
    stop();
  endtask
endmodule

/* testbench/test_rcr_regs.sv */
`timescale 1ns/100ps

// ----------------
// Register block test
// ----------------
module test_rcr_regs;
  logic sys_clk, rst_b, scl_in, sda_pull, addr_select_hi, addr_select_lo, ref_clk_in;
  logic feed_overcurrent_in, feed_load_in, gain_loop_engaged_in, pll_lock_in;
  logic [4:0] factory_trim_code, gain_loop_threshold, lowpass_trim_code, lowpass_trim_applied;
  logic sda_out, sda_oe, clock_out_divider, fractional_mode, reserved_synth_bit, ref_divide_two;
  logic pump_current_select, second_lo_divider, gain_loop_off, feed_guard_off, front_stage_off;
  logic rear_stage_off, synth_off, clock_buffer_off, backend_gain_boost, lowpass_trim_source;
  logic test_route_main, test_route_ref, buffered_clock_out;
  logic [6:0] divider_whole_part;
  logic [19:0] divider_fraction_part;
  logic [1:0] reserved_pump_bits, lowpass_corner_nudge;
  logic [3:0] front_gain_cutback;
  logic [2:0] test_select;
  int num_errors = 0;
  int comparisons = 0;
  // Open-drain data line with pull-up: low while either side pulls it.
  wire logic sda_in = !((sda_oe && !sda_out) || sda_pull);

  rcr_regs rcr_regs_i (.sys_clk, .rst_b, .scl_in, .sda_in, .sda_out, .sda_oe, .addr_select_hi, .addr_select_lo,
    .feed_overcurrent_in, .feed_load_in, .gain_loop_engaged_in, .pll_lock_in, .ref_clk_in, .factory_trim_code,
    .clock_out_divider, .divider_whole_part, .divider_fraction_part, .fractional_mode, .reserved_synth_bit,
    .reserved_pump_bits, .ref_divide_two, .pump_current_select, .second_lo_divider, .gain_loop_off,
    .feed_guard_off, .front_stage_off, .rear_stage_off, .synth_off, .clock_buffer_off, .gain_loop_threshold,
    .lowpass_corner_nudge, .backend_gain_boost, .front_gain_cutback, .lowpass_trim_source, .lowpass_trim_code,
    .lowpass_trim_applied, .test_select, .test_route_main, .test_route_ref, .buffered_clock_out);
  rcr_master rcr_master_i (.sys_clk, .scl(scl_in), .sda_pull, .sda(sda_in));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = !sys_clk;
  end
  always #80 ref_clk_in = !ref_clk_in;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  function automatic logic [7:0] reg_view(input int i);
    case (i)
      0: return {clock_out_divider, divider_whole_part};
      1: return {reserved_synth_bit, reserved_pump_bits, fractional_mode, divider_fraction_part[19:16]};
      2: return divider_fraction_part[15:8];
      3: return divider_fraction_part[7:0];
      4: return {ref_divide_two, pump_current_select, second_lo_divider, gain_loop_off, feed_guard_off,
        front_stage_off, rear_stage_off, synth_off};
      5: return {gain_loop_threshold, lowpass_corner_nudge, backend_gain_boost};
      6: return {front_gain_cutback, clock_buffer_off, test_select};
      default: return {2'b00, lowpass_trim_source, lowpass_trim_code};
    endcase
  endfunction

  // Spare registers have no output, so only the mapped ones are compared.
  task automatic check_regs(input logic [7:0] e [0:9]);
    for (int i = 0; i < rcr_pkg::REG_SLOTS; i++)
      if (i != 7 && i != 8)
        check(reg_view(i), e[i]);
  endtask

  task automatic count_rises(input int lo, input int hi);
    int n;
    logic prev;
    n = 0;
    prev = buffered_clock_out;
    repeat (640)
    begin
      @(negedge sys_clk);
      if (buffered_clock_out === 1'b1 && prev === 1'b0)
        n++;
      prev = buffered_clock_out;
    end
    check(n >= lo && n <= hi, 1'b1);
  endtask

  initial
  begin
    logic [7:0] q [$];
    logic [7:0] e [0:9];
    logic [7:0] b0, b1;
    logic [15:0] acks;
    logic ack;
    logic [3:0] st;
    rst_b = 1'b0;
    ref_clk_in = 1'b0;
    {addr_select_hi, addr_select_lo} = 2'b00;
    {gain_loop_engaged_in, feed_overcurrent_in, feed_load_in, pll_lock_in} = 4'h0;
    factory_trim_code = 5'h13;
    repeat (4) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge sys_clk);
    check_regs(rcr_pkg::REG_RESET);
    check(lowpass_trim_applied, 5'h13);
    count_rises(39, 41);
    for (int c = 0; c < 4; c++)
    begin
      st = {c[1:0], ~c[1:0]};
      {addr_select_hi, addr_select_lo} = c[1:0];
      {gain_loop_engaged_in, feed_overcurrent_in, feed_load_in, pll_lock_in} = st;
      for (int k = 1; k < 4; k++)
      begin
        q = '{8'hc0 + 8'(2 * k)};
        rcr_master_i.write_frame(q, acks);
        check(acks[0], c == k);
      end
      rcr_master_i.read_frame(8'hc1 + 8'(2 * c), ack, b0, b1);
      check(ack, c != 0);
      if (c != 0)
      begin
        check(b0, rcr_pkg::RESERVED_BYTE);
        check(b1, {4'h0, st});
      end
    end
    q = '{8'hc6, 8'h00, 8'hd5, 8'h0a, 8'h3c, 8'ha7, 8'h9a, 8'h7b, 8'ha1, 8'hff, 8'hff, 8'hf4};
    rcr_master_i.write_frame(q, acks);
    check(acks, 16'h0fff);
    for (int i = 0; i < 10; i++)
      e[i] = q[i + 2] & rcr_pkg::REG_WMASK[i];
    check_regs(e);
    check(lowpass_trim_applied, 5'h14);
    check({test_route_main, test_route_ref}, 2'b10);
    count_rises(19, 21);
    q = '{8'hc6, 8'h05, 8'h84, 8'h5a, 8'h5a, 8'ha5, 8'h0e, 8'hff};
    rcr_master_i.write_frame(q, acks);
    check(acks, 16'h00ff);
    for (int i = 5; i < 10; i++)
      e[i] = q[i - 3] & rcr_pkg::REG_WMASK[i];
    check_regs(e);
    check(lowpass_trim_applied, 5'h13);
    check({test_route_main, test_route_ref}, 2'b01);
    count_rises(0, 0);
    // A reset in mid-run must bring every register back from written values.
    rst_b = 1'b0;
    repeat (4) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge sys_clk);
    check_regs(rcr_pkg::REG_RESET);
    check(lowpass_trim_applied, 5'h13);
    check({test_route_main, test_route_ref}, 2'b00);
    tally_and_finish();
  end

  // The sequence needs about 83k cycles; the limit keeps a hang inside the run budget.
  initial
  begin
    #950000;
    num_errors++;
    tally_and_finish();
  end
endmodule

bind rcr_regs rcr_regs_chk rcr_regs_chk_i (.sys_clk, .rst_b, .scl_in, .sda_out, .sda_oe, .addr_select_hi,
  .addr_select_lo, .lowpass_trim_source, .lowpass_trim_code, .lowpass_trim_applied, .test_select,
  .test_route_main, .test_route_ref, .clock_buffer_off, .buffered_clock_out);
